// [rrse_pkg.sv]
package rrse_pkg;

  // Operation codes presented on exec_op.
  localparam logic [1:0] OP_RETURN = 2'h0;
  localparam logic [1:0] OP_ROT_L  = 2'h1;
  localparam logic [1:0] OP_ROT_R  = 2'h2;
  localparam logic [1:0] OP_SLEEP  = 2'h3;

  // Destination select of the rotate operations.
  localparam logic DEST_W    = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Widths and reset values.
  localparam int         DATA_W         = 8;
  localparam int         FADDR_W        = 7;
  localparam int         PC_W           = 13;
  localparam int         WDT_W          = 8;
  localparam int         PRESC_W        = 8;
  localparam logic       PD_N_RST       = 1'b1;
  localparam logic       TO_N_RST       = 1'b1;
  localparam logic [7:0] WDT_CLEAR_VAL  = 8'h00;
  localparam logic [7:0] PRESC_CLEAR_VAL = 8'h00;

  // Occupancy of the return operation in instruction cycles.
  localparam int RETURN_CYCLES = 2;

  typedef enum logic [2:0] {
    RRSE_IDLE  = 3'b001,
    RRSE_RET2  = 3'b010,
    RRSE_SLEEP = 3'b100
  } rrse_state_e;

endpackage

// [rrse_rotator.sv]
`timescale 1ns/1ps

module rrse_rotator #(
  parameter int DATA_W = 8
) (
  input  wire logic              dir_right,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              cin,
  output logic      [DATA_W-1:0] dout,
  output logic                   cout
);

  always_comb begin
    if (dir_right) begin
      dout = {cin, din[DATA_W-1:1]};
      cout = din[0];
    end else begin
      dout = {din[DATA_W-2:0], cin};
      cout = din[DATA_W-1];
    end
  end

endmodule // rrse_rotator

// [rrse_exec.sv]
`timescale 1ns/1ps

module rrse_exec #(
  parameter int PC_W    = rrse_pkg::PC_W,
  parameter int WDT_W   = rrse_pkg::WDT_W,
  parameter int PRESC_W = rrse_pkg::PRESC_W
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        exec_valid,
  input  wire logic [1:0]                  exec_op,
  input  wire logic [rrse_pkg::FADDR_W-1:0] file_addr,
  input  wire logic                        dest_sel,
  input  wire logic [rrse_pkg::DATA_W-1:0] file_rdata,
  input  wire logic                        carry_in,
  input  wire logic [PC_W-1:0]             stack_top_value,
  input  wire logic                        wdt_enable,
  input  wire logic                        wake_req,
  output logic                             exec_ready,
  output logic                             stack_pop,
  output logic                             pc_load,
  output logic      [PC_W-1:0]             pc_value,
  output logic                             w_we,
  output logic                             file_we,
  output logic      [rrse_pkg::FADDR_W-1:0] file_waddr,
  output logic      [rrse_pkg::DATA_W-1:0] result_data,
  output logic                             carry_we,
  output logic                             carry_out,
  output logic                             power_down_flag_n,
  output logic                             timeout_flag_n,
  output logic      [WDT_W-1:0]            watchdog_counter,
  output logic      [PRESC_W-1:0]          wdt_prescaler,
  output logic                             sleep_mode,
  output logic                             osc_stop
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    rrse_pkg::rrse_state_e            state;
    logic                             pop;
    logic                             pc_ld;
    logic [PC_W-1:0]                  pc;
    logic                             w_we;
    logic                             f_we;
    logic [rrse_pkg::FADDR_W-1:0]     f_addr;
    logic [rrse_pkg::DATA_W-1:0]      result;
    logic                             c_we;
    logic                             c_val;
    logic                             pd_n;
    logic                             to_n;
    logic [WDT_W-1:0]                 wdt;
    logic [PRESC_W-1:0]               presc;
  } rrse_regs_s;

  rrse_regs_s                  st_r;
  rrse_regs_s                  st_nxt;
  logic                        take;
  logic [rrse_pkg::DATA_W-1:0] rot_data;
  logic                        rot_carry;

  function automatic logic is_rotate(input logic [1:0] op);
    return (op == rrse_pkg::OP_ROT_L) || (op == rrse_pkg::OP_ROT_R);
  endfunction

  assign exec_ready = (st_r.state == rrse_pkg::RRSE_IDLE);
  assign take       = exec_valid && exec_ready;

  rrse_rotator #(
    .DATA_W (rrse_pkg::DATA_W)
  ) u_rot (
    .dir_right (exec_op == rrse_pkg::OP_ROT_R),
    .din       (file_rdata),
    .cin       (carry_in),
    .dout      (rot_data),
    .cout      (rot_carry)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt       = st_r;
    st_nxt.pop   = 1'b0;
    st_nxt.pc_ld = 1'b0;
    st_nxt.w_we  = 1'b0;
    st_nxt.f_we  = 1'b0;
    st_nxt.c_we  = 1'b0;

    // The watchdog keeps counting in sleep, since it is one of the ways out.
    if (wdt_enable) begin
      st_nxt.presc = st_r.presc + PRESC_W'(1);
      if (st_r.presc == {PRESC_W{1'b1}}) begin
        st_nxt.wdt = st_r.wdt + WDT_W'(1);
      end
    end

    unique case (st_r.state)
      rrse_pkg::RRSE_IDLE: begin
        if (take) begin
          unique case (exec_op)
            rrse_pkg::OP_RETURN: begin
              st_nxt.pop   = 1'b1;
              st_nxt.pc_ld = 1'b1;
              st_nxt.pc    = stack_top_value;
              st_nxt.state = rrse_pkg::RRSE_RET2;
            end
            rrse_pkg::OP_ROT_L,
            rrse_pkg::OP_ROT_R: begin
              st_nxt.result = rot_data;
              st_nxt.c_we   = 1'b1;
              st_nxt.c_val  = rot_carry;
              st_nxt.f_addr = file_addr;
              st_nxt.w_we   = (dest_sel == rrse_pkg::DEST_W);
              st_nxt.f_we   = (dest_sel == rrse_pkg::DEST_FILE);
            end
            rrse_pkg::OP_SLEEP: begin
              st_nxt.wdt   = WDT_W'(rrse_pkg::WDT_CLEAR_VAL);
              st_nxt.presc = PRESC_W'(rrse_pkg::PRESC_CLEAR_VAL);
              st_nxt.pd_n  = 1'b0;
              st_nxt.to_n  = 1'b1;
              st_nxt.state = rrse_pkg::RRSE_SLEEP;
            end
          endcase
        end
      end
      rrse_pkg::RRSE_RET2: begin
        // Second instruction cycle of a return: no new work is taken.
        st_nxt.state = rrse_pkg::RRSE_IDLE;
      end
      rrse_pkg::RRSE_SLEEP: begin
        // Wake-up sources are decoded elsewhere; this only leaves the state.
        if (wake_req) begin
          st_nxt.state = rrse_pkg::RRSE_IDLE;
        end
      end
      default: begin
        st_nxt.state = rrse_pkg::RRSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.state  <= rrse_pkg::RRSE_IDLE;
      st_r.pop    <= 1'b0;
      st_r.pc_ld  <= 1'b0;
      st_r.pc     <= '0;
      st_r.w_we   <= 1'b0;
      st_r.f_we   <= 1'b0;
      st_r.f_addr <= '0;
      st_r.result <= '0;
      st_r.c_we   <= 1'b0;
      st_r.c_val  <= 1'b0;
      st_r.pd_n   <= rrse_pkg::PD_N_RST;
      st_r.to_n   <= rrse_pkg::TO_N_RST;
      st_r.wdt    <= WDT_W'(rrse_pkg::WDT_CLEAR_VAL);
      st_r.presc  <= PRESC_W'(rrse_pkg::PRESC_CLEAR_VAL);
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign stack_pop         = st_r.pop;
  assign pc_load           = st_r.pc_ld;
  assign pc_value          = st_r.pc;
  assign w_we              = st_r.w_we;
  assign file_we           = st_r.f_we;
  assign file_waddr        = st_r.f_addr;
  assign result_data       = st_r.result;
  assign carry_we          = st_r.c_we;
  assign carry_out         = st_r.c_val;
  assign power_down_flag_n = st_r.pd_n;
  assign timeout_flag_n    = st_r.to_n;
  assign watchdog_counter  = st_r.wdt;
  assign wdt_prescaler     = st_r.presc;
  assign sleep_mode        = (st_r.state == rrse_pkg::RRSE_SLEEP);
  // The oscillator gate follows the sleep state with no extra stage.
  assign osc_stop          = (st_r.state == rrse_pkg::RRSE_SLEEP);

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_take_return;
    take && (exec_op == rrse_pkg::OP_RETURN);
  endsequence

  sequence s_take_sleep;
    take && (exec_op == rrse_pkg::OP_SLEEP);
  endsequence

  sequence s_take_rot;
    take && is_rotate(exec_op);
  endsequence

  sequence s_flags_updated;
    !power_down_flag_n && timeout_flag_n;
  endsequence

  sequence s_asleep;
    sleep_mode && osc_stop;
  endsequence

  a_return_loads_pc: assert property (
    s_take_return |=> stack_pop && pc_load && !carry_we && (pc_value == $past(stack_top_value)))
    else $error("return did not pop and load the counter");

  a_return_two_cycles: assert property (
    s_take_return |=> !exec_ready ##1 exec_ready)
    else $error("return did not take exactly two cycles");

  a_rot_left_value: assert property (
    s_take_rot and (exec_op == rrse_pkg::OP_ROT_L) |=>
      carry_we && (result_data == {$past(file_rdata[6:0]), $past(carry_in)}))
    else $error("rotate left result wrong");

  a_rot_right_value: assert property (
    s_take_rot and (exec_op == rrse_pkg::OP_ROT_R) |=>
      carry_we && (result_data == {$past(carry_in), $past(file_rdata[7:1])}))
    else $error("rotate right result wrong");

  a_rot_carry_out: assert property (
    s_take_rot |=> carry_out == ($past(exec_op) == rrse_pkg::OP_ROT_L ? $past(file_rdata[7]) : $past(file_rdata[0])))
    else $error("rotate carry out wrong");

  a_dest_working: assert property (
    s_take_rot and (dest_sel == rrse_pkg::DEST_W) |=> w_we && !file_we)
    else $error("destination zero wrote the file register");

  a_dest_file: assert property (
    s_take_rot and (dest_sel == rrse_pkg::DEST_FILE) |=> file_we && !w_we && (file_waddr == $past(file_addr)))
    else $error("destination one did not write back");

  a_sleep_wdt_clear: assert property (
    s_take_sleep |=> (watchdog_counter == '0) && (wdt_prescaler == '0))
    else $error("sleep did not clear the watchdog");

  a_sleep_pd_clear: assert property (
    s_take_sleep |=> !power_down_flag_n && !carry_we)
    else $error("sleep did not clear power-down flag");

  a_sleep_to_set: assert property (
    s_take_sleep |=> timeout_flag_n)
    else $error("sleep did not set time-out flag");

  a_sleep_enter: assert property (
    s_take_sleep |=> s_flags_updated and s_asleep and !exec_ready)
    else $error("sleep state not entered with oscillator stopped");

  // Side effects that must stay absent are guarded too: a stray write pulse would corrupt
  // a register that the core never meant to touch, and no check on wanted values would notice.
  sequence s_flags_kept;
    $stable(power_down_flag_n) && $stable(timeout_flag_n);
  endsequence

  sequence s_no_writes;
    !w_we && !file_we && !carry_we;
  endsequence

  a_return_no_status: assert property (
    s_take_return |=> s_flags_kept and s_no_writes)
    else $error("return changed a status flag or wrote a register");

  a_pop_with_load: assert property (
    stack_pop |-> pc_load)
    else $error("stack popped without loading the counter");

  a_pop_single: assert property (
    stack_pop |=> !stack_pop && !pc_load)
    else $error("return popped the stack twice");

  a_rot_left_flags: assert property (
    s_take_rot and (exec_op == rrse_pkg::OP_ROT_L) |=> s_flags_kept and !stack_pop)
    else $error("rotate left changed a flag other than carry");

  a_rot_right_flags: assert property (
    s_take_rot and (exec_op == rrse_pkg::OP_ROT_R) |=> s_flags_kept and !stack_pop)
    else $error("rotate right changed a flag other than carry");

  a_asleep_flags: assert property (
    sleep_mode |-> s_flags_updated)
    else $error("status flags lost while asleep");

  a_asleep_quiet: assert property (
    sleep_mode |-> s_no_writes and !stack_pop and !exec_ready)
    else $error("work done while asleep");

  a_asleep_stays: assert property (
    sleep_mode && !wake_req |=> s_asleep)
    else $error("sleep left without a wake request");

  // Leaving sleep needs only the wake request; the oscillator gate must drop with the state,
  // otherwise the core would report itself ready while its clock is still held.
  a_wake_resumes: assert property (
    sleep_mode && wake_req |=> exec_ready && !sleep_mode && !osc_stop)
    else $error("core did not resume after the wake request");

endmodule // rrse_exec

// [testbench.sv]
`timescale 1ns/1ps

module testbench;
  logic        clk;
  logic        sys_rst;
  logic        exec_valid;
  logic [1:0]  exec_op;
  logic [6:0]  file_addr;
  logic        dest_sel;
  logic [7:0]  file_rdata;
  logic        carry_in;
  logic [12:0] stack_top_value;
  logic        wdt_enable;
  logic        wake_req;
  logic        exec_ready;
  logic        stack_pop;
  logic        pc_load;
  logic [12:0] pc_value;
  logic        w_we;
  logic        file_we;
  logic [6:0]  file_waddr;
  logic [7:0]  result_data;
  logic        carry_we;
  logic        carry_out;
  logic        power_down_flag_n;
  logic        timeout_flag_n;
  logic [7:0]  watchdog_counter;
  logic [7:0]  wdt_prescaler;
  logic        sleep_mode;
  logic        osc_stop;
  int          miscompares;
  int          checks_done;
  int          cycle_count;

  rrse_exec u_rrse_exec (.clk(clk), .sys_rst(sys_rst), .exec_valid(exec_valid), .exec_op(exec_op),
    .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata), .carry_in(carry_in),
    .stack_top_value(stack_top_value), .wdt_enable(wdt_enable), .wake_req(wake_req),
    .exec_ready(exec_ready), .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
    .w_we(w_we), .file_we(file_we), .file_waddr(file_waddr), .result_data(result_data),
    .carry_we(carry_we), .carry_out(carry_out), .power_down_flag_n(power_down_flag_n),
    .timeout_flag_n(timeout_flag_n), .watchdog_counter(watchdog_counter),
    .wdt_prescaler(wdt_prescaler), .sleep_mode(sleep_mode), .osc_stop(osc_stop));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A rotate is held pending during the dead cycle so an acceptance there would show as a carry write.
  task automatic t_return();
    exec_valid = 1'b1;
    exec_op = rrse_pkg::OP_RETURN;
    stack_top_value = 13'h1ABC;
    step();
    exec_op = rrse_pkg::OP_ROT_L;
    chk(stack_pop, 1'b1, "pop");
    chk(pc_load, 1'b1, "pc load");
    chk(pc_value, 13'h1ABC, "pc value");
    chk(carry_we, 1'b0, "return carry");
    chk(exec_ready, 1'b0, "dead cycle");
    step();
    chk(exec_ready, 1'b1, "ready after two");
    chk(stack_pop, 1'b0, "single pop");
    chk(carry_we, 1'b0, "refused rotate");
    step();
    exec_valid = 1'b0;
    chk(carry_we, 1'b1, "held rotate taken");
    chk(pc_load, 1'b0, "single load");
    step();
    $display("t_return done");
  endtask

  logic [1:0] rot_op [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
  logic [7:0] rot_din [4] = '{8'hE6, 8'h80, 8'h01, 8'h7E};
  logic       rot_cin [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  task automatic t_rotate();
    logic [7:0] exp_d;
    logic       exp_c;
    exec_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      exec_op = rot_op[i];
      dest_sel = i[0];
      file_rdata = rot_din[i];
      carry_in = rot_cin[i];
      file_addr = 7'h7F ^ 7'(i);
      exp_d = (rot_op[i] == rrse_pkg::OP_ROT_L) ? {rot_din[i][6:0], rot_cin[i]} : {rot_cin[i], rot_din[i][7:1]};
      exp_c = (rot_op[i] == rrse_pkg::OP_ROT_L) ? rot_din[i][7] : rot_din[i][0];
      step();
      chk(result_data, exp_d, "rotate data");
      chk(carry_out, exp_c, "rotate carry");
      chk(carry_we, 1'b1, "carry write");
      chk(w_we, !i[0], "w write");
      chk(file_we, i[0], "file write");
      chk(stack_pop, 1'b0, "no pop");
      if (i[0]) begin
        chk(file_waddr, 7'h7F ^ 7'(i), "file address");
      end
    end
    exec_valid = 1'b0;
    step();
    chk(carry_we, 1'b0, "carry pulse");
    $display("t_rotate done");
  endtask

  // The watchdog runs long enough to pass a prescaler wrap, so the clear is visible.
  task automatic t_sleep();
    wdt_enable = 1'b1;
    repeat (300) step();
    chk(wdt_prescaler, 8'h2C, "prescaler running");
    chk(watchdog_counter, 8'h01, "watchdog running");
    exec_valid = 1'b1;
    exec_op = rrse_pkg::OP_SLEEP;
    wdt_enable = 1'b0;
    step();
    exec_op = rrse_pkg::OP_ROT_R;
    chk(watchdog_counter, 8'h00, "watchdog");
    chk(wdt_prescaler, 8'h00, "prescaler");
    chk(power_down_flag_n, 1'b0, "pd flag");
    chk(timeout_flag_n, 1'b1, "to flag");
    chk(sleep_mode, 1'b1, "sleep");
    chk(osc_stop, 1'b1, "osc stop");
    chk(exec_ready, 1'b0, "sleep busy");
    repeat (3) step();
    chk(carry_we, 1'b0, "asleep refuses");
    chk(sleep_mode, 1'b1, "still asleep");
    wake_req = 1'b1;
    step();
    wake_req = 1'b0;
    chk(sleep_mode, 1'b0, "woken");
    chk(exec_ready, 1'b1, "ready on wake");
    chk(carry_we, 1'b0, "no work on wake edge");
    step();
    exec_valid = 1'b0;
    chk(carry_we, 1'b1, "rotate after wake");
    chk(result_data, 8'hBF, "wake rotate data");
    chk(power_down_flag_n, 1'b0, "pd held");
    chk(timeout_flag_n, 1'b1, "to held");
    $display("t_sleep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    exec_valid = 1'b0;
    exec_op = 2'h0;
    file_addr = 7'h00;
    dest_sel = 1'b0;
    file_rdata = 8'h00;
    carry_in = 1'b0;
    stack_top_value = 13'h0000;
    wdt_enable = 1'b0;
    wake_req = 1'b0;
    miscompares = 0;
    checks_done = 0;
    cycle_count = 0;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk(power_down_flag_n, 1'b1, "pd reset");
    chk(timeout_flag_n, 1'b1, "to reset");
    chk(exec_ready, 1'b1, "ready reset");
    t_return();
    t_rotate();
    t_sleep();
    wrap_up();
  end
endmodule // testbench
